// [core/rfl_pkg.sv]
// constants shared by the reader fifo and transmit length block
package rfl_pkg;
   // register addresses on the host register port
   localparam logic [4:0] RFL_ADDR_FIFO_STATUS = 5'h1c;
   localparam logic [4:0] RFL_ADDR_TX_LEN_UPPER = 5'h1d;
   localparam logic [4:0] RFL_ADDR_TX_LEN_LOWER = 5'h1e;
   // field positions in the status and lower length registers
   localparam int         RFL_OVF_BIT          = 7;
   localparam int         RFL_PARTIAL_FLAG_BIT = 0;
   // reset value and value read from unmapped addresses
   localparam logic [7:0] RFL_LEN_RESET        = 8'h00;
   localparam logic [7:0] RFL_UNMAPPED_READ    = 8'h00;
   // fifo depth in bytes, last slot index and output buffer depth in words
   localparam logic [7:0] RFL_FIFO_DEPTH       = 8'h7f;
   localparam logic [6:0] RFL_LAST_PTR         = 7'h7e;
   localparam logic [1:0] RFL_SKID_DEPTH       = 2'h2;
endpackage : rfl_pkg

// [core/rfl_fifo_txlen.sv]
// reader fifo bookkeeping, overflow status and transmit length registers
// What this block does
// - the status register top bit sets when a byte is presented while 127 bytes are held or ready is still low in the first enabled cycle.
// - the low seven status bits give the binary count of bytes held and waiting to be read.
// - the upper length register holds bits 11 to 4 of the complete-byte count.
// - the lower length register carries bits 3 to 0 of that count in its upper nibble.
// - bits 3 to 1 of the lower length register give the partial byte width, used only with the flag.
// - bit 0 of the lower length register marks the last byte as narrower than eight bits.
// - both length registers read zero after reset, while enable is low, and after end of frame with no write in that cycle.
`timescale 1ns/10ps
`default_nettype none
module rfl_fifo_txlen
   import rfl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   input  wire logic        en_i,
   input  wire logic [4:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        in_valid_i,
   input  wire logic [7:0]  in_data_i,
   output logic             in_ready_o,
   output logic             out_valid_o,
   output logic      [7:0]  out_data_o,
   input  wire logic        out_ready_i,
   input  wire logic        tx_eof_i,
   output logic      [11:0] tx_bytes_o,
   output logic             tx_partial_o,
   output logic      [2:0]  tx_partial_bits_o
);

   // one struct holds every flop of the block, the byte store included
   // keeping the store here lets reset and enable clear it in one place
   // the cost is a wide clear of the whole store, accepted for simplicity
   typedef struct packed {
      logic              en_s1;
      logic              en_s2;
      logic [126:0][7:0] mem;
      logic [6:0]        wp;
      logic [6:0]        rp;
      logic [6:0]        mc;
      logic [1:0][7:0]   skid;
      logic [1:0]        nb;
      logic              ovalid;
      logic              ovf;
      logic [7:0]        len_hi;
      logic [7:0]        len_lo;
      logic [2:0]        pbits;
      logic [7:0]        rdata;
      logic              in_rdy;
   } rfl_state_t;

   localparam rfl_state_t RFL_STATE_RESET = '0;

   rfl_state_t st_r;
   rfl_state_t st_nxt;

   // pointers wrap after the last of the 127 slots
   function automatic logic [6:0] rfl_ptr_inc(input logic [6:0] p);
      rfl_ptr_inc = (p == RFL_LAST_PTR) ? 7'h00 : p + 7'h01;
   endfunction : rfl_ptr_inc

   // bytes waiting to be read: memory plus output buffer
   function automatic logic [7:0] rfl_total(input rfl_state_t s);
      rfl_total = {1'b0, s.mc} + {6'h00, s.nb};
   endfunction : rfl_total

   // status byte: sticky overflow on top, held count below
   function automatic logic [7:0] rfl_status(input rfl_state_t s);
      logic [7:0] t;
      t = rfl_total(s);
      rfl_status = {s.ovf, t[6:0]};
   endfunction : rfl_status

   // next state: enable sync, fifo moves, registers, read mux
   always_comb begin : next_state
      logic       push;
      logic       take;
      logic       move;
      logic [1:0] nb_tmp;
      // locals get a value first so no path leaves them unassigned
      push = 1'b0;
      take = 1'b0;
      move = 1'b0;
      nb_tmp = 2'h0;
      st_nxt = st_r;
      st_nxt.en_s1 = en_i;
      st_nxt.en_s2 = st_r.en_s1;
      // in_rdy equals "fewer than 127 held" except in the first enabled cycle, when it is still low; refusal and overflow agree
      push = in_valid_i && st_r.in_rdy;
      take = (st_r.nb != 2'h0) && out_ready_i;
      nb_tmp = st_r.nb;
      if (in_valid_i && !st_r.in_rdy && st_r.en_s2) begin
         st_nxt.ovf = 1'b1;
      end
      // drain the output buffer first so a word is freed for refill
      if (take) begin
         st_nxt.skid[0] = st_r.skid[1];
         nb_tmp = nb_tmp - 2'h1;
      end
      move = (st_r.mc != 7'h00) && (nb_tmp < RFL_SKID_DEPTH);
      if (move) begin
         st_nxt.skid[nb_tmp[0]] = st_r.mem[st_r.rp];
         nb_tmp = nb_tmp + 2'h1;
         st_nxt.rp = rfl_ptr_inc(st_r.rp);
      end
      st_nxt.nb = nb_tmp;
      // valid comes from its own flop so the output is not decoded
      st_nxt.ovalid = nb_tmp != 2'h0;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data_i;
         st_nxt.wp = rfl_ptr_inc(st_r.wp);
      end
      // one up per byte in, one down per byte moved to the buffer
      st_nxt.mc = st_r.mc + {6'h00, push} - {6'h00, move};
      // end of frame clears the length; a host write in the same cycle wins
      if (tx_eof_i) begin
         st_nxt.len_hi = RFL_LEN_RESET;
         st_nxt.len_lo = RFL_LEN_RESET;
      end
      if (reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_UPPER) begin
         st_nxt.len_hi = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_LOWER) begin
         st_nxt.len_lo = reg_wdata_i;
      end
      // partial width only counts while the flag is set
      st_nxt.pbits = st_nxt.len_lo[RFL_PARTIAL_FLAG_BIT] ? st_nxt.len_lo[3:1] : 3'h0;
      // read data is registered and kept until the next read
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            RFL_ADDR_FIFO_STATUS:  st_nxt.rdata = rfl_status(st_r);
            RFL_ADDR_TX_LEN_UPPER: st_nxt.rdata = st_r.len_hi;
            RFL_ADDR_TX_LEN_LOWER: st_nxt.rdata = st_r.len_lo;
            default:               st_nxt.rdata = RFL_UNMAPPED_READ;
         endcase
      end
      // ready looks at the next count so a full store refuses at once
      st_nxt.in_rdy = rfl_total(st_nxt) < RFL_FIFO_DEPTH;
      // enable low holds everything cleared except the synchroniser
      // the synchroniser keeps running so enable can come back
      if (!st_r.en_s2) begin
         st_nxt = RFL_STATE_RESET;
         st_nxt.en_s1 = en_i;
         st_nxt.en_s2 = st_r.en_s1;
      end
   end

   // single register stage; clock enable freezes all of it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= RFL_STATE_RESET;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   // outputs come straight from the state flops
   assign reg_rdata_o       = st_r.rdata;
   assign in_ready_o        = st_r.in_rdy;
   assign out_valid_o       = st_r.ovalid;
   assign out_data_o        = st_r.skid[0];
   assign tx_bytes_o        = {st_r.len_hi, st_r.len_lo[7:4]};
   assign tx_partial_o      = st_r.len_lo[RFL_PARTIAL_FLAG_BIT];
   assign tx_partial_bits_o = st_r.pbits;

   // all checks run on the one clock and rest while reset is low
   default clocking rfl_cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_OVF_ON_FULL_WRITE: assert property (
      ce_i && st_r.en_s2 && in_valid_i && !in_ready_o |=> st_r.ovf)
      else $error("overflow not set after write into full fifo");

   AST_STATUS_READ: assert property (
      ce_i && reg_rd_i && reg_addr_i == RFL_ADDR_FIFO_STATUS && st_r.en_s2
      |=> reg_rdata_o == {$past(st_r.ovf), $past(st_r.mc) + {5'h00, $past(st_r.nb)}})
      else $error("status read does not show count and overflow");

   AST_UPPER_WRITE: assert property (
      ce_i && st_r.en_s2 && reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_UPPER
      |=> tx_bytes_o[11:4] == $past(reg_wdata_i))
      else $error("upper length bits do not follow write");

   AST_LOWER_WRITE: assert property (
      ce_i && st_r.en_s2 && reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_LOWER
      |=> tx_bytes_o[3:0] == $past(reg_wdata_i[7:4]) && tx_partial_o == $past(reg_wdata_i[0]))
      else $error("lower length bits do not follow write");

   AST_PARTIAL_GATED: assert property (
      !tx_partial_o |-> tx_partial_bits_o == 3'h0)
      else $error("partial width shown without flag");

   AST_PARTIAL_WIDTH: assert property (
      ce_i && st_r.en_s2 && reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_LOWER && reg_wdata_i[0]
      |=> tx_partial_o && tx_partial_bits_o == $past(reg_wdata_i[3:1]))
      else $error("partial width not taken with flag set");

   AST_EOF_CLEAR: assert property (
      ce_i && tx_eof_i && !reg_wr_i |=> tx_bytes_o == 12'h000 && !tx_partial_o)
      else $error("length not cleared at end of frame");

   AST_DISABLE_CLEAR: assert property (
      ce_i && !st_r.en_s2 |=> tx_bytes_o == 12'h000 && reg_rdata_o == 8'h00 && !out_valid_o)
      else $error("state not cleared while disabled");

   AST_COUNT_UP: assert property (
      ce_i && st_r.en_s2 && in_valid_i && in_ready_o && !(out_valid_o && out_ready_i)
      |=> rfl_total(st_r) == $past(rfl_total(st_r)) + 8'h01)
      else $error("count did not rise on write");

   AST_COUNT_DOWN: assert property (
      ce_i && st_r.en_s2 && !in_valid_i && out_valid_o && out_ready_i
      |=> rfl_total(st_r) == $past(rfl_total(st_r)) - 8'h01)
      else $error("count did not fall on read");

   AST_COUNT_RANGE: assert property (
      rfl_total(st_r) <= RFL_FIFO_DEPTH)
      else $error("count above 127");

   // overflow is sticky and only a refused byte may raise it
   AST_OVF_STICKY: assert property (
      ce_i && st_r.en_s2 && st_r.ovf |=> st_r.ovf)
      else $error("overflow flag dropped while enabled");

   AST_OVF_ONLY_ON_REFUSAL: assert property (
      ce_i && st_r.en_s2 && !st_r.ovf && !(in_valid_i && !in_ready_o) |=> !st_r.ovf)
      else $error("overflow set without a refused byte");

   // ready and the count must agree, or a byte could slip past the limit
   AST_READY_MEANS_ROOM: assert property (
      in_ready_o |-> rfl_total(st_r) < RFL_FIFO_DEPTH)
      else $error("ready shown with no room left");

   AST_FULL_REFUSES: assert property (
      rfl_total(st_r) == RFL_FIFO_DEPTH |-> !in_ready_o)
      else $error("ready shown with 127 bytes held");

   AST_COUNT_HOLD: assert property (
      ce_i && st_r.en_s2 && !(in_valid_i && in_ready_o) && !(out_valid_o && out_ready_i)
      |=> rfl_total(st_r) == $past(rfl_total(st_r)))
      else $error("count moved with no byte in or out");

   AST_COUNT_SWAP: assert property (
      ce_i && st_r.en_s2 && in_valid_i && in_ready_o && out_valid_o && out_ready_i
      |=> rfl_total(st_r) == $past(rfl_total(st_r)))
      else $error("count moved when one byte came in and one went out");

   // a stalled consumer must see the same head byte until it takes it
   AST_OUT_HOLD: assert property (
      ce_i && st_r.en_s2 && out_valid_o && !out_ready_i
      |=> out_valid_o && $stable(out_data_o))
      else $error("head byte changed before it was taken");

   // read-back of the length registers matches what the outputs show
   AST_UPPER_READ: assert property (
      ce_i && st_r.en_s2 && reg_rd_i && reg_addr_i == RFL_ADDR_TX_LEN_UPPER
      |=> reg_rdata_o == $past(tx_bytes_o[11:4]))
      else $error("upper length read-back differs from count");

   AST_LOWER_READ: assert property (
      ce_i && st_r.en_s2 && reg_rd_i && reg_addr_i == RFL_ADDR_TX_LEN_LOWER
      |=> reg_rdata_o[7:4] == $past(tx_bytes_o[3:0]) && reg_rdata_o[0] == $past(tx_partial_o))
      else $error("lower length read-back differs from count");

   // with no write and no end of frame the length must not drift
   AST_LEN_HOLD: assert property (
      ce_i && st_r.en_s2 && !tx_eof_i && !reg_wr_i
      |=> $stable(tx_bytes_o) && $stable(tx_partial_o) && $stable(tx_partial_bits_o))
      else $error("length changed with no write");

   AST_UPPER_KEEP: assert property (
      ce_i && st_r.en_s2 && reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_LOWER && !tx_eof_i
      |=> $stable(tx_bytes_o[11:4]))
      else $error("upper length bits changed by a lower write");

   AST_PARTIAL_FLAG_CLEAR: assert property (
      ce_i && st_r.en_s2 && reg_wr_i && reg_addr_i == RFL_ADDR_TX_LEN_LOWER && !reg_wdata_i[0]
      |=> !tx_partial_o && tx_partial_bits_o == 3'h0)
      else $error("partial byte shown after flag written low");

   AST_EOF_PARTIAL_CLEAR: assert property (
      ce_i && tx_eof_i && !reg_wr_i |=> tx_partial_bits_o == 3'h0)
      else $error("partial width kept after end of frame");

   // while enable is low nothing may be accepted or flagged
   AST_EN_LOW_NO_READY: assert property (
      ce_i && !st_r.en_s2 |=> !in_ready_o && !st_r.ovf && !tx_partial_o)
      else $error("fifo active while disabled");

   // read data is held between reads so a slow host can pick it up late
   AST_READ_HOLD: assert property (
      ce_i && st_r.en_s2 && !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data changed without a read");

endmodule : rfl_fifo_txlen
`default_nettype wire

// [bench/rfl_sink.sv]
// consumer model at the fifo output, stalling now and then and checking byte order
`timescale 1ns/10ps
`default_nettype none
module rfl_sink (
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic       valid_i,
   input  wire logic [7:0] data_i,
   output logic            ready_o,
   output logic      [7:0] taken_o,
   output logic      [7:0] bad_o
);
   logic [1:0] ph_r = 2'h0;
   initial ready_o = 1'b0;
   initial taken_o = 8'h00;
   initial bad_o = 8'h00;
   // one stall in four, so the buffer sees both slow and prompt takes
   always @(posedge clk_i) begin
      if (valid_i && ready_o) begin
         if (data_i !== taken_o) bad_o <= bad_o + 8'h01;
         taken_o <= taken_o + 8'h01;
      end
      ph_r <= ph_r + 2'h1;
      ready_o <= go_i && (ph_r != 2'h3);
   end
endmodule : rfl_sink
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the fifo bookkeeping and transmit length registers
`timescale 1ns/10ps
`default_nettype none
module tb import rfl_pkg::*;;
   logic clk_i = 1'b0, reset_n_i = 1'b0, en_i = 1'b1, ce_i = 1'b1, go = 1'b0;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, in_valid_i = 1'b0, tx_eof_i = 1'b0;
   logic [4:0] reg_addr_i = 5'h00;
   logic [7:0] reg_wdata_i = 8'h00, in_data_i = 8'h00, reg_rdata_o, out_data_o, taken, bad;
   logic in_ready_o, out_valid_o, out_ready_i, tx_partial_o;
   logic [11:0] tx_bytes_o;
   logic [2:0] tx_partial_bits_o;
   int fails = 0, num_checks = 0, cyc = 0;
   rfl_fifo_txlen i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .en_i(en_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
      .in_data_i(in_data_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
      .out_data_o(out_data_o), .out_ready_i(out_ready_i), .tx_eof_i(tx_eof_i),
      .tx_bytes_o(tx_bytes_o), .tx_partial_o(tx_partial_o),
      .tx_partial_bits_o(tx_partial_bits_o));
   rfl_sink i_sink (.clk_i(clk_i), .go_i(go), .valid_i(out_valid_o), .data_i(out_data_o),
      .ready_o(out_ready_i), .taken_o(taken), .bad_o(bad));
   initial forever #50 clk_i = ~clk_i;
   task end_sim;
      $display("checks %0d failures %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // a hung handshake lands here instead of running forever
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_sim;
      end
   end
   task chk(input logic [11:0] got, input logic [11:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask : wr
   // read data is registered, so it is sampled just after the strobe's edge
   task rdc(input logic [4:0] a, input logic [7:0] e, input string m);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk({4'h0, reg_rdata_o}, {4'h0, e}, m);
   endtask : rdc
   task t_len;
      wr(RFL_ADDR_TX_LEN_UPPER, 8'ha5);
      wr(RFL_ADDR_TX_LEN_LOWER, 8'h3b);
      wr(RFL_ADDR_FIFO_STATUS, 8'h55);
      chk(tx_bytes_o, 12'ha53, "count");
      chk({9'h0, tx_partial_bits_o}, 12'h005, "bits");
      chk({11'h0, tx_partial_o}, 12'h001, "flag");
      rdc(RFL_ADDR_TX_LEN_LOWER, 8'h3b, "lower");
      rdc(RFL_ADDR_FIFO_STATUS, 8'h00, "status ro");
      rdc(5'h1f, RFL_UNMAPPED_READ, "unmapped");
      wr(RFL_ADDR_TX_LEN_LOWER, 8'h3a);
      chk({8'h0, tx_partial_o, tx_partial_bits_o}, 12'h000, "no flag");
   endtask : t_len
   task t_eof;
      @(posedge clk_i) tx_eof_i <= 1'b1;
      @(posedge clk_i) tx_eof_i <= 1'b0;
      rdc(RFL_ADDR_TX_LEN_UPPER, RFL_LEN_RESET, "eof up");
      rdc(RFL_ADDR_TX_LEN_LOWER, RFL_LEN_RESET, "eof low");
      chk(tx_bytes_o, 12'h000, "eof out");
   endtask : t_eof
   // consumer stalled: fill to capacity, then offer bytes for nine cycles past full
   task t_fill;
      @(posedge clk_i) in_valid_i <= 1'b1;
      repeat (135) @(posedge clk_i) if (in_ready_o) in_data_i <= in_data_i + 8'h01;
      @(posedge clk_i) in_valid_i <= 1'b0;
      chk({11'h0, in_ready_o}, 12'h000, "full");
      rdc(RFL_ADDR_FIFO_STATUS, 8'hff, "overflow");
   endtask : t_fill
   task t_drain;
      @(posedge clk_i) go <= 1'b1;
      repeat (400) @(posedge clk_i);
      chk({4'h0, taken}, {4'h0, RFL_FIFO_DEPTH}, "taken");
      chk({4'h0, bad}, 12'h000, "order");
      chk({11'h0, in_ready_o}, 12'h001, "room");
      rdc(RFL_ADDR_FIFO_STATUS, 8'h80, "empty");
   endtask : t_drain
   task t_en;
      wr(RFL_ADDR_TX_LEN_UPPER, 8'h77);
      @(posedge clk_i) en_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      en_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rdc(RFL_ADDR_TX_LEN_UPPER, RFL_LEN_RESET, "en up");
      rdc(RFL_ADDR_FIFO_STATUS, 8'h00, "en status");
   endtask : t_en
   initial begin
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdc(RFL_ADDR_TX_LEN_UPPER, RFL_LEN_RESET, "rst up");
      rdc(RFL_ADDR_TX_LEN_LOWER, RFL_LEN_RESET, "rst low");
      t_len;
      t_eof;
      t_fill;
      t_drain;
      t_en;
      end_sim;
   end
endmodule : tb
`default_nettype wire
